// [bench/tb_uvp_host.sv]
/* Self-checking bench: reads, one partial program pass cut by reset, then one full pass.
   Assumes the EPROM model on the far side. */
`timescale 1ns/1ps
module tb_uvp_host;
	import uvp_pkg::*;
	localparam int PC = 2000;
	localparam int NW = 6;
	localparam int NL = 2;
	logic core_clk = 0, sys_rst = 1, rdReq = 0, progStart = 0;
	logic rdValid, progAddrReq, busy, progDone, sel, lvl, pulse, oeN, qOe;
	logic [ADDR_W-1:0] rdAddr = 0, wal;
	logic [DATA_W-1:0] progData = 0, lastIn = 0, dataPinsIn, q, rdData, dOut;
	logic [DATA_W-1:0] pat [NW];
	logic [DATA_W-1:0] expMem [WORDS];
	logic [DATA_W-1:0] expQ [$];
	logic [15:0] expDone [$];
	int bad_count = 0, n_compared = 0, seed = 32'heb63_26b1, reqs = 0;
	always #25 core_clk = ~core_clk;
	// Released pins show a changing pattern, not the last value
	assign dataPinsIn = !oeN ? dOut : qOe ? q : ~lastIn;
	always @(posedge core_clk) lastIn <= dataPinsIn;
	uvp_host #(.PULSE_CYCLES(PC), .LOOP_COUNT(NL), .WORD_COUNT(NW)) uut (.core_clk,
		.sys_rst, .rdReq, .rdAddr, .rdValid, .rdData, .progStart, .progAddrReq, .progData, .busy,
		.progDone, .word_address_lines(wal), .select_program_enable(sel),
		.selProgLevel(lvl), .programPulse(pulse), .dataPinsIn, .dataPinsOut(dOut),
		.dataPinsOe_n(oeN));
	uvp_eprom_model dev (.word_address_lines(wal), .select_program_enable(sel),
		.selProgLevel(lvl), .programPulse(pulse), .pinData(dataPinsIn), .q, .qOe);
	task automatic check_byte(input logic [DATA_W-1:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic check_done(input logic [15:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic end_of_test;
		if (expQ.size() != 0 || expDone.size() != 0) bad_count++;
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic do_reset;
		#1 sys_rst = 1'b1;
		repeat (6) @(posedge core_clk);
		#1 sys_rst = 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge core_clk);
		#1 rdReq = 1'b1;
		rdAddr = a;
		expQ.push_back(expMem[a]);
		@(posedge core_clk);
		#1 rdReq = 1'b0;
		for (int k = 0; k < 40 && busy !== 1'b0; k++) @(posedge core_clk);
	endtask
	// A cut below NW resets once word cut-1 is done; otherwise all loops run to the exit
	task automatic prog_pass(input int cut);
		for (int i = 0; i < NW; i++) begin
			pat[i] = DATA_W'($random(seed));
			if (i < cut) expMem[i] = expMem[i] & pat[i];
		end
		reqs = 0;
		if (cut >= NW) expDone.push_back({4'b0101, 12'(NW * NL)});
		@(posedge core_clk);
		#1 progStart = 1'b1;
		@(posedge core_clk);
		#1 progStart = 1'b0;
		if (cut < NW) begin
			while (reqs < cut + 1) @(posedge core_clk);
			do_reset;
			repeat (250) @(posedge core_clk);
		end else begin
			while (busy !== 1'b0) @(posedge core_clk);
		end
	endtask
	always @(posedge core_clk) begin
		if (progAddrReq === 1'b1) begin
			reqs <= reqs + 1;
			progData <= #1 (wal < NW) ? pat[wal] : 8'hFF;
		end
		if (rdValid === 1'b1) begin
			if (expQ.size() == 0) bad_count++;
			else check_byte(rdData, expQ.pop_front());
		end
		if (progDone === 1'b1) begin
			if (expDone.size() == 0) bad_count++;
			else check_done({busy, sel, lvl, oeN, 12'(reqs)}, expDone.pop_front());
		end
	end
	initial begin
		#5000000;
		bad_count++;
		end_of_test;
	end
	initial begin
		foreach (expMem[i]) expMem[i] = ERASED_WORD;
		do_reset;
		repeat (8) rd(ADDR_W'(NW + $unsigned($random(seed)) % (WORDS - NW)));
		prog_pass(3);
		prog_pass(NW);
		for (int i = 0; i < NW; i++) rd(ADDR_W'(i));
		rd(10'h3FF);
		repeat (3) @(posedge core_clk);
		end_of_test;
	end
endmodule // tb_uvp_host
bind uvp_host uvp_host_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) mon (.core_clk, .sys_rst,
	.rdReq, .rdAddr, .rdValid, .progStart, .progAddrReq, .busy, .word_address_lines,
	.select_program_enable, .selProgLevel, .programPulse, .dataPinsOut, .dataPinsOe_n);

// [bench/uvp_eprom_model.sv]
/* Behavioural 1024x8 UV EPROM.
   Assumes the bench resolves the shared data pins from qOe. */
`timescale 1ns/1ps
module uvp_eprom_model (
	// Pins from host
	input wire logic [uvp_pkg::ADDR_W-1:0] word_address_lines,
	input wire logic select_program_enable,
	input wire logic selProgLevel,
	input wire logic programPulse,
	input wire logic [uvp_pkg::DATA_W-1:0] pinData,
	// Device drive
	output logic [uvp_pkg::DATA_W-1:0] q,
	output logic qOe
);
	import uvp_pkg::*;
	logic [DATA_W-1:0] mem [WORDS];
	logic bad = 1'b0;
	logic armed = 1'b0;
	initial foreach (mem[i]) mem[i] = ERASED_WORD;
	always @(posedge programPulse) if (selProgLevel) mem[word_address_lines] &= pinData;
	// outputs garbage after exit
	// The first drop from unknown at reset is not an exit
	always @(posedge selProgLevel) armed = 1'b1;
	always @(negedge selProgLevel) if (armed) begin
		bad = 1'b1;
		#10000 bad = 1'b0;
	end
	assign qOe = !select_program_enable && !selProgLevel;
	assign q = bad ? ~mem[word_address_lines] : mem[word_address_lines];
endmodule // uvp_eprom_model

// [bench/uvp_host_monitor.sv]
/* Pin-sequence checker for uvp_host.
   Assumes a bind onto uvp_host; sees its ports only. */
`timescale 1ns/1ps
module uvp_host_monitor #(parameter int PULSE_CYCLES = 20000) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// User side
	input wire logic rdReq,
	input wire logic [uvp_pkg::ADDR_W-1:0] rdAddr,
	input wire logic rdValid,
	input wire logic progStart,
	input wire logic progAddrReq,
	input wire logic busy,
	// Pins
	input wire logic [uvp_pkg::ADDR_W-1:0] word_address_lines,
	input wire logic select_program_enable,
	input wire logic selProgLevel,
	input wire logic programPulse,
	input wire logic [uvp_pkg::DATA_W-1:0] dataPinsOut,
	input wire logic dataPinsOe_n
);
	import uvp_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [CNT_W-1:0] hiCnt, next_hiCnt;
	logic [ADDR_W-1:0] lastReq, next_lastReq;
	always_comb begin
		next_hiCnt = programPulse ? hiCnt + 1'b1 : '0;
		next_lastReq = progAddrReq ? word_address_lines : lastReq;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hiCnt <= '0;
			lastReq <= '0;
		end else begin
			hiCnt <= next_hiCnt;
			lastReq <= next_lastReq;
		end
	end
	a_read_start: assert property (
		rdReq && !busy && !progStart |=> busy && !select_program_enable
		&& word_address_lines == $past(rdAddr)) else $error("read start wrong");
	a_read_answer: assert property (
		rdReq && !busy && !progStart |-> ##[8:24] rdValid) else $error("no read answer");
	a_no_pulse_read: assert property (
		!selProgLevel |-> !programPulse) else $error("pulse outside program mode");
	a_drive_in_prog: assert property (
		!dataPinsOe_n |-> selProgLevel) else $error("data driven outside program mode");
	a_pulse_ctx: assert property (
		programPulse |-> selProgLevel && !dataPinsOe_n && $stable(dataPinsOut)
		&& $stable(word_address_lines)) else $error("pulse without stable setup");
	a_pulse_width: assert property (
		$fell(programPulse) |-> hiCnt == PULSE_CYCLES)
		else $error("pulse width wrong");
	a_hold_after: assert property (
		$fell(programPulse) |-> (selProgLevel && !dataPinsOe_n
		&& $stable(word_address_lines))[*8]) else $error("hold after pulse broken");
	a_addr_order: assert property (
		progAddrReq && word_address_lines != 10'h000 |-> word_address_lines
		== lastReq + 10'h001) else $error("address not ascending");
	a_exit_order: assert property (
		$fell(selProgLevel) |-> $past(dataPinsOe_n) && !programPulse
		&& !select_program_enable) else $error("exit order wrong");
	a_addr_with_req: assert property (
		!dataPinsOe_n && $changed(word_address_lines) |-> progAddrReq)
		else $error("address moved while data driven");
endmodule // uvp_host_monitor

// [rtl/uvp_host.sv]
`timescale 1ns/1ps
/*
 * Host controller for a 1024x8 UV EPROM: timed reads and full
 * programming loops. Assumes external drivers turn selProgLevel into
 * +12V and programPulse into +25V on the device pins.
 */
module uvp_host #(
	parameter int PULSE_CYCLES = uvp_pkg::PULSE_CYC,
	parameter int LOOP_COUNT = uvp_pkg::LOOPS,
	parameter int WORD_COUNT = uvp_pkg::WORDS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// User read port
	input wire logic rdReq,
	input wire logic [uvp_pkg::ADDR_W-1:0] rdAddr,
	output logic rdValid,
	output logic [uvp_pkg::DATA_W-1:0] rdData,
	// User program port: data fetched per address
	input wire logic progStart,
	output logic progAddrReq,
	input wire logic [uvp_pkg::DATA_W-1:0] progData,
	output logic busy,
	output logic progDone,
	// EPROM pins
	output logic [uvp_pkg::ADDR_W-1:0] word_address_lines,
	output logic select_program_enable,
	output logic selProgLevel,
	output logic programPulse,
	input wire logic [uvp_pkg::DATA_W-1:0] dataPinsIn,
	output logic [uvp_pkg::DATA_W-1:0] dataPinsOut,
	output logic dataPinsOe_n
);
	import uvp_pkg::*;
	// Refuse pulse widths outside 0.1 to 1.0 ms, and loop and word counts the loop counter and memory cannot serve
	if (PULSE_CYCLES < PULSE_MIN_CYC || PULSE_CYCLES > PULSE_CYC || LOOP_COUNT < 1
		|| LOOP_COUNT > 65536 || WORD_COUNT < 1 || WORD_COUNT > WORDS) begin : g_bad_param
		$error("uvp_host: pulse width, loop or word count out of range");
	end
	// ****************************************
	// Pin synchroniser
	// ****************************************
	logic [DATA_W-1:0] pinMeta;
	logic [DATA_W-1:0] pinSync;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= dataPinsIn;
			pinSync <= pinMeta;
		end
	end
	// ****************************************
	// Sequencer
	// ****************************************
	uvp_timer_if tif ();
	uvp_timer u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.tmr(tif.tmr)
	);
	uvp_state_t state, next_state;
	logic [ADDR_W-1:0] addr, next_addr;
	logic [DATA_W-1:0] wdata, next_wdata, rdq, next_rdq;
	logic [15:0] loopCnt, next_loopCnt;
	logic sel, next_sel, lvl, next_lvl, pulse, next_pulse, oe_n, next_oe_n;
	logic rv, next_rv, pd, next_pd, areq, next_areq, bsy, next_bsy;
	logic tStart;
	logic [CNT_W-1:0] tLoad;
	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n + 2);
	endfunction
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_wdata = wdata;
		next_rdq = rdq;
		next_loopCnt = loopCnt;
		next_sel = sel;
		next_lvl = lvl;
		next_pulse = 1'b0;
		next_oe_n = oe_n;
		next_rv = 1'b0;
		next_pd = 1'b0;
		next_areq = 1'b0;
		next_bsy = bsy;
		tStart = 1'b0;
		tLoad = '0;
		unique case (state)
			UVP_IDLE: begin
				next_sel = 1'b1;
				if (progStart) begin
					next_lvl = 1'b1;
					next_bsy = 1'b1;
					next_addr = ADDR_RESET;
					next_loopCnt = '0;
					next_areq = 1'b1;
					tStart = 1'b1;
					tLoad = cyc(SETUP_CYC);
					next_state = UVP_PE_SETUP;
				end else if (rdReq) begin
					next_addr = rdAddr;
					next_sel = 1'b0;
					next_bsy = 1'b1;
					tStart = 1'b1;
					tLoad = cyc(ACCESS_CYC + 2);
					next_state = UVP_RD_WAIT;
				end
			end
			UVP_RD_WAIT: if (tif.done) begin
				next_rdq = pinSync;
				next_rv = 1'b1;
				next_sel = 1'b1;
				next_bsy = 1'b0;
				next_state = UVP_IDLE;
			end
			UVP_PE_SETUP: if (tif.done) begin
				next_wdata = progData;
				next_oe_n = 1'b0;
				tStart = 1'b1;
				tLoad = cyc(SETUP_CYC);
				next_state = UVP_W_SETUP;
			end
			UVP_W_SETUP: if (tif.done) begin
				next_pulse = 1'b1;
				tStart = 1'b1;
				// Pin stays high for exactly PULSE_CYCLES clocks
				tLoad = cyc(PULSE_CYCLES - 3);
				next_state = UVP_PULSE;
			end
			UVP_PULSE: begin
				next_pulse = !tif.done;
				if (tif.done) begin
					tStart = 1'b1;
					tLoad = cyc(HOLD_CYC);
					next_state = UVP_W_HOLD;
				end
			end
			UVP_W_HOLD: if (tif.done) begin
				if (addr == ADDR_W'(WORD_COUNT - 1) && loopCnt == 16'(LOOP_COUNT - 1)) begin
					tStart = 1'b1;
					tLoad = cyc(PE_HOLD_CYC);
					next_state = UVP_PE_HOLD;
				end else begin
					if (addr == ADDR_W'(WORD_COUNT - 1)) begin
						next_addr = ADDR_RESET;
						next_loopCnt = loopCnt + 1'b1;
					end else begin
						next_addr = addr + 1'b1;
					end
					next_areq = 1'b1;
					tStart = 1'b1;
					tLoad = cyc(1);
					next_state = UVP_PE_SETUP;
				end
			end
			UVP_PE_HOLD: if (tif.done) begin
				next_oe_n = 1'b1;
				tStart = 1'b1;
				tLoad = cyc(1);
				next_state = UVP_REL;
			end
			UVP_REL: if (tif.done) begin
				next_lvl = 1'b0;
				next_sel = 1'b0;
				tStart = 1'b1;
				tLoad = cyc(EXIT_CYC);
				next_state = UVP_EXIT_WAIT;
			end
			UVP_EXIT_WAIT: if (tif.done) begin
				next_sel = 1'b1;
				next_addr = ADDR_RESET;
				next_pd = 1'b1;
				next_bsy = 1'b0;
				next_state = UVP_IDLE;
			end
			default: next_state = UVP_IDLE;
		endcase
	end
	assign tif.start = tStart;
	assign tif.load = tLoad;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= UVP_IDLE;
			addr <= ADDR_RESET;
			wdata <= ERASED_WORD;
			rdq <= '0;
			loopCnt <= '0;
			sel <= 1'b1;
			lvl <= 1'b0;
			pulse <= 1'b0;
			oe_n <= 1'b1;
			rv <= 1'b0;
			pd <= 1'b0;
			areq <= 1'b0;
			bsy <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			wdata <= next_wdata;
			rdq <= next_rdq;
			loopCnt <= next_loopCnt;
			sel <= next_sel;
			lvl <= next_lvl;
			pulse <= next_pulse;
			oe_n <= next_oe_n;
			rv <= next_rv;
			pd <= next_pd;
			areq <= next_areq;
			bsy <= next_bsy;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	// pulse low unless programming
	assign programPulse = pulse;
	assign word_address_lines = addr;
	assign select_program_enable = sel;
	assign selProgLevel = lvl;
	assign dataPinsOut = wdata;
	assign dataPinsOe_n = oe_n;
	assign rdData = rdq;
	assign rdValid = rv;
	assign progDone = pd;
	assign progAddrReq = areq;
	assign busy = bsy;
endmodule // uvp_host

// [rtl/uvp_pkg.sv]
/*
 * Constants and types for the UV EPROM host controller: geometry, pin
 * timings converted to 20 MHz clock cycles, and controller states.
 * Assumes a single 20 MHz clock and external level shifters for +12V/+25V.
 */
// Summary of operation
// - Host keeps the program pulse pin low during reads.
// - Host raises select to program level for the whole sequence.
// - Host presents address and data before each program pulse.
// - Program pulse lasts 0.1 to 1.0 ms, then returns to zero.
// - Host waits at least 1 us after a pulse before next word.
// - Host repeats full loop N times with N times pulse at least 100 ms; defaults give 100 x 1 ms, LOOP_COUNT x pulse is not checked.
// - Each loop starts at address zero and steps upward in order.
// - Exit: end last pulse, then drive select low; device reads again.
// - On exit host releases data pins before changing address.
// - Host holds program level at least 500 ns after last pulse.
package uvp_pkg;
	localparam int CLK_MHZ = 20;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int WORDS = 1024;
	// Timings in ns, converted to cycles of 50 ns
	localparam int ACCESS_NS = 450;
	localparam int SETUP_NS = 10000;
	localparam int PULSE_NS = 1000000;
	localparam int HOLD_NS = 1000;
	localparam int PE_HOLD_NS = 500;
	localparam int EXIT_NS = 10000;
	localparam int PULSE_MIN_NS = 100000;
	localparam int LOOP_TOTAL_NS = 100000000;
	localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ) / 1000;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int PE_HOLD_CYC = (PE_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int EXIT_CYC = (EXIT_NS * CLK_MHZ + 999) / 1000;
	localparam int LOOPS = (LOOP_TOTAL_NS + PULSE_NS - 1) / PULSE_NS;
	localparam int CNT_W = 24;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
	localparam logic [DATA_W-1:0] ERASED_WORD = 8'hFF;
	typedef enum logic [3:0] {
		UVP_IDLE, UVP_RD_SEL, UVP_RD_WAIT, UVP_PE_SETUP, UVP_W_SETUP,
		UVP_PULSE, UVP_W_HOLD, UVP_PE_HOLD, UVP_REL, UVP_EXIT_WAIT
	} uvp_state_t;
endpackage

// [rtl/uvp_timer.sv]
`timescale 1ns/1ps
/*
 * Down-counting delay timer; done is a registered level once the count ends.
 * Assumes start is a one-cycle pulse from the same clock domain.
 */
module uvp_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Sequencer side
	uvp_timer_if.tmr tmr
);
	import uvp_pkg::*;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic done;
	logic next_done;
	always_comb begin
		next_count = count;
		next_done = done;
		if (tmr.start) begin
			next_count = tmr.load;
			next_done = 1'b0;
		end else if (count > 1) begin
			next_count = count - 1'b1;
		end else begin
			next_count = '0;
			next_done = 1'b1;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
			done <= 1'b1;
		end else begin
			count <= next_count;
			done <= next_done;
		end
	end
	assign tmr.done = done;
endmodule // uvp_timer

// [rtl/uvp_timer_if.sv]
`timescale 1ns/1ps
/*
 * Carrier between the sequencer and its delay timer.
 * Assumes both ends share core_clk.
 */
interface uvp_timer_if;
	logic start;
	logic [23:0] load;
	logic done;
	modport ctrl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface
